/* File: inc/fast_adapt_pkg.sv */
package fast_adapt_pkg;
  typedef enum logic [1:0] {RES_FULL, RES_INTERLACE, RES_480P_PICK, RES_480P_AVG} res_mode_t;
  typedef enum logic [1:0] {NEG_IDLE, NEG_CHECK, NEG_ANSWER} neg_state_t;
endpackage

/* File: inc/fast_adapt_regs.svh */
`ifndef FAST_ADAPT_REGS_SVH
`define FAST_ADAPT_REGS_SVH
`define RESULT_ACCEPTED      8'h00
`define RESULT_REJECTED      8'h01
`define COMP_W               10
`define DEPTH_SHIFT          2
`define HSUB_GROUP           2'h3
`define VSUB_GROUP           4'h9
`define PART_COUNT           3'h4
`define FIFO_DEPTH           16
`define FIFO_AW              4
`define MAX_CHANNELS         4'h8
`endif

/* File: logic/adapt_fifo.sv */
`timescale 1ns/1ps
module adapt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_resetn,
  // Write side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Read side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty       = wr_ptr_reg == rd_ptr_reg;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

/* File: logic/fast_av_format_adaptation.sv */
`timescale 1ns/1ps
`include "fast_adapt_regs.svh"
module fast_av_format_adaptation (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_resetn,
  // Adaptation request from the sink
  input  wire logic                      i_req_valid,
  input  wire logic                      i_video_adapt_flag,
  input  wire logic                      i_audio_adapt_flag,
  input  wire logic [2:0]                i_partitions_kept,
  input  wire fast_adapt_pkg::res_mode_t i_req_res_mode,
  input  wire logic [3:0]                i_req_frame_sub,
  input  wire logic                      i_req_color_8bit,
  input  wire logic [3:0]                i_req_channels,
  input  wire logic [3:0]                i_req_audio_sub,
  input  wire logic                      i_req_sample_8bit,
  input  wire logic                      i_split_constant,
  input  wire logic                      i_accept_enable,
  // Response to the sink
  output logic                           o_resp_valid,
  output logic [7:0]                     o_adapt_result,
  // Video input (sender)
  input  wire logic                      i_vid_valid,
  input  wire logic [29:0]               i_vid_pixel,
  input  wire logic                      i_vid_sof,
  input  wire logic                      i_vid_sol,
  input  wire logic [1:0]                i_vid_partition,
  output logic                           o_vid_ready,
  // Video output (sender, reduced)
  output logic                           o_vid_valid,
  output logic [29:0]                    o_vid_pixel,
  output logic [1:0]                     o_vid_partition,
  output logic                           o_vid_split_half,
  input  wire logic                      i_vid_ready,
  // Audio input/output (sender)
  input  wire logic                      i_aud_valid,
  input  wire logic [3:0]                i_aud_channel,
  input  wire logic [9:0]                i_aud_sample,
  output logic                           o_aud_valid,
  output logic [3:0]                     o_aud_channel,
  output logic [9:0]                     o_aud_sample,
  // Receiver side restore
  input  wire logic                      i_rx_valid,
  input  wire logic [29:0]               i_rx_pixel,
  input  wire logic                      i_rx_aud_valid,
  input  wire logic [9:0]                i_rx_aud_sample,
  output logic                           o_disp_valid,
  output logic [29:0]                    o_disp_pixel,
  output logic [1:0]                     o_disp_copy_idx,
  output logic                           o_spk_valid,
  output logic [9:0]                     o_spk_sample,
  output logic [3:0]                     o_spk_channel,
  // Active parameter status
  output logic                           o_video_active,
  output logic                           o_audio_active
);
  import fast_adapt_pkg::*;

  function automatic logic [29:0] shift_pix(input logic [29:0] p, input logic right);
    logic [29:0] r;
    r = '0;
    for (int i = 0; i < 3; i++) begin
      r[i*10 +: 10] = right ? (p[i*10 +: 10] >> `DEPTH_SHIFT) : (p[i*10 +: 10] << `DEPTH_SHIFT);
    end
    return r;
  endfunction

  // Accepted parameter set, shared by both directions
  neg_state_t neg_reg;
  logic       req_ok;
  logic       vid_on_reg, aud_on_reg, col8_reg, smp8_reg;
  res_mode_t  res_reg;
  logic [2:0] part_reg;
  logic [3:0] fsub_reg, chan_reg, asub_reg;
  logic       resp_valid_reg;
  logic [7:0] result_reg;

  assign req_ok = i_accept_enable && (i_video_adapt_flag || i_audio_adapt_flag)
                  && i_partitions_kept != 3'h0 && i_partitions_kept <= `PART_COUNT;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      neg_reg        <= NEG_IDLE;
      resp_valid_reg <= 1'b0;
      result_reg     <= `RESULT_ACCEPTED;
      vid_on_reg     <= 1'b0;
      aud_on_reg     <= 1'b0;
      res_reg        <= RES_FULL;
      part_reg       <= `PART_COUNT;
      fsub_reg       <= 4'h0;
      col8_reg       <= 1'b0;
      chan_reg       <= `MAX_CHANNELS;
      asub_reg       <= 4'h0;
      smp8_reg       <= 1'b0;
    end else begin
      resp_valid_reg <= 1'b0;
      case (neg_reg)
        NEG_IDLE: begin
          if (i_req_valid) begin
            neg_reg <= NEG_ANSWER;
            resp_valid_reg <= 1'b1;
            result_reg <= req_ok ? `RESULT_ACCEPTED : `RESULT_REJECTED;
            if (req_ok) begin
              vid_on_reg <= i_video_adapt_flag;
              aud_on_reg <= i_audio_adapt_flag;
              res_reg    <= i_req_res_mode;
              part_reg   <= i_partitions_kept;
              fsub_reg   <= i_req_frame_sub;
              col8_reg   <= i_req_color_8bit;
              chan_reg   <= i_req_channels;
              asub_reg   <= i_req_audio_sub;
              smp8_reg   <= i_req_sample_8bit;
            end
          end
        end
        NEG_ANSWER: neg_reg <= NEG_IDLE;
        default:    neg_reg <= NEG_IDLE;
      endcase
    end
  end

  // Video position tracking
  logic [0:0] line_par_reg;
  logic       frame_par_reg;
  logic [1:0] hcnt_reg;
  logic [3:0] vcnt_reg, fcnt_reg;
  logic [10:0] avg_acc [3];
  logic       line_par_cur;
  logic       frame_par_cur;
  logic [3:0] vcnt_cur;
  logic [3:0] fcnt_cur;
  logic       keep;
  logic       line_keep;
  logic       pix_keep;
  logic       part_keep;
  logic       frame_keep;
  logic [29:0] v_pix;
  logic [1:0] hpos;
  logic       fifo_in_ready, fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic       fifo_push;

  assign hpos = i_vid_sol ? 2'h0 : hcnt_reg;

  // Position of the beat on the pins, so the first pixel of a line or frame is judged by its own line
  assign line_par_cur  = i_vid_sof ? 1'b0 : (i_vid_sol ? ~line_par_reg[0] : line_par_reg[0]);
  assign frame_par_cur = i_vid_sof ? ~frame_par_reg : frame_par_reg;
  assign vcnt_cur      = i_vid_sof ? 4'h1 : (!i_vid_sol ? vcnt_reg :
                         ((vcnt_reg == `VSUB_GROUP) ? 4'h1 : vcnt_reg + 4'h1));
  assign fcnt_cur      = !i_vid_sof ? fcnt_reg : ((fcnt_reg >= fsub_reg) ? 4'h0 : fcnt_reg + 4'h1);

  always_comb begin
    line_keep = 1'b1;
    pix_keep  = 1'b1;
    case (res_reg)
      RES_INTERLACE: line_keep = line_par_cur == frame_par_cur;
      RES_480P_PICK, RES_480P_AVG: begin
        line_keep = !vcnt_cur[0];
        pix_keep  = hpos == 2'h2;
      end
      default: begin
        line_keep = 1'b1;
        pix_keep  = 1'b1;
      end
    endcase
    if (!vid_on_reg) begin
      line_keep = 1'b1;
      pix_keep  = 1'b1;
    end
  end

  // Sub-packets of the highest partitions are dropped first
  assign part_keep  = !vid_on_reg || ({1'b0, i_vid_partition} < part_reg);
  assign frame_keep = !vid_on_reg || fsub_reg == 4'h0 || fcnt_cur == 4'h0;
  assign keep       = line_keep && pix_keep && part_keep && frame_keep;

  always_comb begin
    v_pix = i_vid_pixel;
    if (vid_on_reg && res_reg == RES_480P_AVG) begin
      for (int i = 0; i < 3; i++) begin
        v_pix[i*10 +: 10] = 10'((32'(i_vid_pixel[i*10 +: 10]) + 32'(avg_acc[i])) / 3);
      end
    end
    if (vid_on_reg && col8_reg) begin
      v_pix = shift_pix(v_pix, 1'b1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      avg_acc[0] <= '0;
      avg_acc[1] <= '0;
      avg_acc[2] <= '0;
    end else if (i_vid_valid && o_vid_ready) begin
      for (int i = 0; i < 3; i++) begin
        avg_acc[i] <= (hpos == 2'h2) ? 11'h000 :
                      ((hpos == 2'h0) ? 11'({1'b0, i_vid_pixel[i*10 +: 10]})
                                      : avg_acc[i] + 11'(i_vid_pixel[i*10 +: 10]));
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hcnt_reg      <= 2'h0;
      vcnt_reg      <= 4'h1;
      line_par_reg  <= 1'b0;
      // First frame after reset counts as frame zero and is never dropped
      frame_par_reg <= 1'b1;
      fcnt_reg      <= 4'hf;
    end else if (i_vid_valid && o_vid_ready) begin
      hcnt_reg      <= (hpos == `HSUB_GROUP - 2'h1) ? 2'h0 : hpos + 2'h1;
      vcnt_reg      <= vcnt_cur;
      line_par_reg  <= line_par_cur;
      frame_par_reg <= frame_par_cur;
      fcnt_reg      <= fcnt_cur;
    end
  end

  assign o_vid_ready = fifo_in_ready;
  assign fifo_push   = i_vid_valid && keep;

  adapt_fifo #(.WIDTH(32), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (fifo_push),
    .i_in_data   ({i_vid_partition, v_pix}),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (i_vid_ready)
  );

  logic split_reg;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_vid_valid      <= 1'b0;
      o_vid_pixel      <= '0;
      o_vid_partition  <= 2'h0;
      o_vid_split_half <= 1'b0;
      split_reg        <= 1'b0;
    end else begin
      o_vid_valid     <= fifo_out_valid && i_vid_ready;
      o_vid_pixel     <= fifo_out_data[29:0];
      o_vid_partition <= fifo_out_data[31:30];
      if (fifo_out_valid && i_vid_ready) begin
        split_reg <= ~split_reg;
      end
      o_vid_split_half <= i_split_constant && vid_on_reg && part_reg == 3'h2 && split_reg;
    end
  end

  // Audio sender
  logic [3:0] acnt_reg;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acnt_reg      <= 4'h0;
      o_aud_valid   <= 1'b0;
      o_aud_channel <= 4'h0;
      o_aud_sample  <= '0;
    end else begin
      o_aud_valid   <= 1'b0;
      o_aud_channel <= i_aud_channel;
      o_aud_sample  <= (aud_on_reg && smp8_reg) ? i_aud_sample >> `DEPTH_SHIFT : i_aud_sample;
      if (i_aud_valid) begin
        if (i_aud_channel == 4'h0) begin
          acnt_reg <= (acnt_reg >= asub_reg) ? 4'h0 : acnt_reg + 4'h1;
        end
        o_aud_valid <= !aud_on_reg ||
                       ((i_aud_channel < chan_reg) && (asub_reg == 4'h0 || acnt_reg == 4'h0));
      end
    end
  end

  // Receiver restore: replicate pixels, partitions and samples
  logic [1:0] rep_reg;
  logic [1:0] rep_max;
  assign rep_max = !vid_on_reg ? 2'h0 : (res_reg == RES_480P_PICK || res_reg == RES_480P_AVG) ? 2'h2
                   : (part_reg < `PART_COUNT ? 2'(`PART_COUNT / part_reg - 3'h1) : 2'h0);
  logic [29:0] hold_pix;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rep_reg         <= 2'h0;
      hold_pix        <= '0;
      o_disp_valid    <= 1'b0;
      o_disp_pixel    <= '0;
      o_disp_copy_idx <= 2'h0;
    end else begin
      o_disp_valid <= 1'b0;
      if (i_rx_valid) begin
        hold_pix        <= i_rx_pixel;
        rep_reg         <= rep_max;
        o_disp_valid    <= 1'b1;
        o_disp_copy_idx <= 2'h0;
        o_disp_pixel    <= (vid_on_reg && col8_reg) ? shift_pix(i_rx_pixel, 1'b0) : i_rx_pixel;
      end else if (rep_reg != 2'h0) begin
        rep_reg         <= rep_reg - 2'h1;
        o_disp_valid    <= 1'b1;
        o_disp_copy_idx <= o_disp_copy_idx + 2'h1;
        o_disp_pixel    <= (vid_on_reg && col8_reg) ? shift_pix(hold_pix, 1'b0) : hold_pix;
      end
    end
  end

  logic [3:0] arep_reg;
  logic [9:0] ahold;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arep_reg      <= 4'h0;
      ahold         <= '0;
      o_spk_valid   <= 1'b0;
      o_spk_sample  <= '0;
      o_spk_channel <= 4'h0;
    end else begin
      o_spk_valid <= 1'b0;
      if (i_rx_aud_valid) begin
        ahold         <= (aud_on_reg && smp8_reg) ? i_rx_aud_sample << `DEPTH_SHIFT : i_rx_aud_sample;
        arep_reg      <= aud_on_reg ? `MAX_CHANNELS - 4'h1 : 4'h0;
        o_spk_valid   <= 1'b1;
        o_spk_channel <= 4'h0;
        o_spk_sample  <= (aud_on_reg && smp8_reg) ? i_rx_aud_sample << `DEPTH_SHIFT : i_rx_aud_sample;
      end else if (arep_reg != 4'h0) begin
        arep_reg      <= arep_reg - 4'h1;
        o_spk_valid   <= 1'b1;
        o_spk_channel <= o_spk_channel + 4'h1;
        o_spk_sample  <= ahold;
      end
    end
  end

  assign o_resp_valid   = resp_valid_reg;
  assign o_adapt_result = result_reg;
  assign o_video_active = vid_on_reg;
  assign o_audio_active = aud_on_reg;

  a_resp_follows: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_req_valid && neg_reg == NEG_IDLE |=> o_resp_valid) else $error("no response");
  a_result_legal: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_resp_valid |-> o_adapt_result <= 8'h01) else $error("reserved result");
  a_reject_keeps: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_resp_valid && o_adapt_result == 8'h01 |-> $stable(vid_on_reg)) else $error("format changed");
  a_accept_flags: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_req_valid && neg_reg == NEG_IDLE && req_ok |=> vid_on_reg == $past(i_video_adapt_flag))
    else $error("flag not taken");
  a_part_drop: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    vid_on_reg && {1'b0, i_vid_partition} >= part_reg |-> !fifo_push) else $error("partition kept");
  a_field_parity: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    vid_on_reg && res_reg == RES_INTERLACE && line_par_cur != frame_par_cur |-> !fifo_push)
    else $error("wrong line kept");
  a_vert_nine: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    vid_on_reg && res_reg == RES_480P_PICK && vcnt_cur[0] |-> !fifo_push) else $error("line kept");
  a_pix_shift: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rx_valid && vid_on_reg && col8_reg |=> o_disp_pixel[1:0] == 2'h0) else $error("no left shift");
  c_accept: cover property (@(posedge i_core_clk) o_resp_valid && o_adapt_result == 8'h00);
  c_reject: cover property (@(posedge i_core_clk) o_resp_valid && o_adapt_result == 8'h01);
  c_repeat: cover property (@(posedge i_core_clk) o_disp_valid && o_disp_copy_idx == 2'h2);
endmodule

/* File: verification/sink_ready_model.sv */
`timescale 1ns/1ps
module sink_ready_model (
  // Clock and control
  input  wire logic       i_core_clk,
  input  wire logic [1:0] i_ready_mode,
  // Video sink handshake
  output logic            o_vid_ready
);
  int seed = 32'h6d31;
  // Mode 0 always ready, 1 random stalls, 2 stalled; a slow display shows up as back-pressure
  initial o_vid_ready = 1'b1;
  always @(negedge i_core_clk) begin
    case (i_ready_mode)
      2'h0:    o_vid_ready <= 1'b1;
      2'h1:    o_vid_ready <= ($random(seed) % 3) != 0;
      default: o_vid_ready <= 1'b0;
    endcase
  end
endmodule

/* File: verification/test_fast_av_format_adaptation.sv */
`timescale 1ns/1ps
module test_fast_av_format_adaptation;
  import fast_adapt_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_req_valid = 1'b0;
  logic        i_video_adapt_flag = 1'b0;
  logic        i_audio_adapt_flag = 1'b0;
  logic        i_accept_enable = 1'b0;
  logic        i_req_color_8bit = 1'b0;
  logic        i_req_sample_8bit = 1'b0;
  logic [2:0]  i_partitions_kept = 3'h0;
  res_mode_t   i_req_res_mode = RES_FULL;
  logic [3:0]  i_req_frame_sub = 4'h0;
  logic [3:0]  i_req_channels = 4'h8;
  logic [3:0]  i_req_audio_sub = 4'h0;
  logic        i_vid_valid = 1'b0;
  logic        i_vid_sof = 1'b0;
  logic        i_vid_sol = 1'b0;
  logic [29:0] i_vid_pixel = 30'h0;
  logic [1:0]  i_vid_partition = 2'h0;
  logic        i_aud_valid = 1'b0;
  logic [3:0]  i_aud_channel = 4'h0;
  logic [9:0]  i_aud_sample = 10'h0;
  logic        i_vid_ready;
  logic        i_split_constant = 1'b1;
  logic        i_rx_valid = 1'b0, i_rx_aud_valid = 1'b0;
  logic [29:0] i_rx_pixel = 30'h0;
  logic [9:0]  i_rx_aud_sample = 10'h0;
  logic        o_disp_valid, o_spk_valid, o_vid_split_half;
  logic [29:0] o_disp_pixel;
  logic [1:0]  o_disp_copy_idx;
  logic [9:0]  o_spk_sample;
  logic [3:0]  o_spk_channel;
  logic [31:0] qd[$], qs[$];
  int          cur_dn = 1, cur_an = 1, nvout = 0;
  logic        o_resp_valid, o_vid_ready, o_vid_valid, o_aud_valid, o_video_active, o_audio_active;
  logic [7:0]  o_adapt_result;
  logic [29:0] o_vid_pixel;
  logic [1:0]  o_vid_partition;
  logic [3:0]  o_aud_channel;
  logic [9:0]  o_aud_sample;
  logic [1:0]  rdy_mode = 2'h0;
  logic [31:0] qv[$], qa[$], qr[$];
  logic [2:0]  cur_parts = 3'h4;
  logic        cur_c8 = 1'b0, cur_s8 = 1'b0, exp_v = 1'b0, exp_a = 1'b0;
  int          num_errors = 0, tests_run = 0, seed = 32'h6d31;

  fast_av_format_adaptation dut (
    .i_core_clk, .i_resetn, .i_req_valid, .i_video_adapt_flag, .i_audio_adapt_flag, .i_partitions_kept,
    .i_req_res_mode, .i_req_frame_sub, .i_req_color_8bit, .i_req_channels, .i_req_audio_sub,
    .i_req_sample_8bit, .i_split_constant, .i_accept_enable, .o_resp_valid, .o_adapt_result,
    .i_vid_valid, .i_vid_pixel, .i_vid_sof, .i_vid_sol, .i_vid_partition, .o_vid_ready, .o_vid_valid,
    .o_vid_pixel, .o_vid_partition, .o_vid_split_half, .i_vid_ready, .i_aud_valid, .i_aud_channel,
    .i_aud_sample, .o_aud_valid, .o_aud_channel, .o_aud_sample, .i_rx_valid, .i_rx_pixel,
    .i_rx_aud_valid, .i_rx_aud_sample, .o_disp_valid, .o_disp_pixel, .o_disp_copy_idx,
    .o_spk_valid, .o_spk_sample, .o_spk_channel, .o_video_active, .o_audio_active);

  sink_ready_model peer (.i_core_clk, .i_ready_mode(rdy_mode), .o_vid_ready(i_vid_ready));

  always #20 i_core_clk = ~i_core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Params flip after the request edge so a late sample is caught
  task automatic req(input logic v, a, en, c8, s8, input logic [2:0] p, input res_mode_t m, input logic dbl);
    logic ok;
    ok = en && (v || a) && p >= 3'h1 && p <= 3'h4;
    @(negedge i_core_clk);
    {i_req_valid, i_video_adapt_flag, i_audio_adapt_flag, i_accept_enable} = {1'b1, v, a, en};
    {i_partitions_kept, i_req_color_8bit, i_req_sample_8bit} = {p, c8, s8};
    i_req_res_mode = m;
    {i_req_frame_sub, i_req_audio_sub, i_req_channels} = ok ? 12'h008 : 12'($random(seed));
    if (ok) begin
      {exp_v, exp_a, cur_c8, cur_s8} = {v, a, v & c8, a & s8};
      cur_parts = v ? p : 3'h4;
      cur_dn = !v ? 1 : (m == RES_480P_PICK || m == RES_480P_AVG) ? 3 : 4 / int'(p);
      cur_an = a ? 8 : 1;
    end
    qr.push_back({22'h0, ok ? 8'h00 : 8'h01, exp_v, exp_a});
    @(negedge i_core_clk);
    if (!dbl) i_req_valid = 1'b0;
    {i_video_adapt_flag, i_partitions_kept, i_accept_enable} = {~v, ~p, 1'b0};
    @(negedge i_core_clk);
    i_req_valid = 1'b0;
    @(negedge i_core_clk);
  endtask

  task automatic pix(input logic [1:0] part, input logic sof, input logic keep, output logic acc);
    logic [29:0] px, ex;
    px = 30'($random(seed));
    ex = cur_c8 ? {2'h0, px[29:22], 2'h0, px[19:12], 2'h0, px[9:2]} : px;
    @(negedge i_core_clk);
    {i_vid_valid, i_vid_pixel, i_vid_partition, i_vid_sof, i_vid_sol} = {1'b1, px, part, sof, 1'b1};
    i_aud_valid = 1'b0;
    acc = o_vid_ready;
    @(posedge i_core_clk);
    if (acc && keep && {1'b0, part} < cur_parts) qv.push_back({part, ex});
  endtask

  task automatic aud(input logic [3:0] ch);
    logic [9:0] s;
    s = 10'($random(seed));
    @(negedge i_core_clk);
    {i_aud_valid, i_aud_channel, i_aud_sample} = {1'b1, ch, s};
    i_vid_valid = 1'b0;
    @(posedge i_core_clk);
    qa.push_back({18'h0, ch, cur_s8 ? {2'h0, s[9:2]} : s});
  endtask

  // One received pixel and sample; expected copies follow the accepted request
  task automatic rx();
    logic [29:0] px, ex;
    logic [9:0]  s, es;
    px = 30'($random(seed));
    s  = 10'($random(seed));
    ex = cur_c8 ? {px[27:20], 2'h0, px[17:10], 2'h0, px[7:0], 2'h0} : px;
    es = cur_s8 ? {s[7:0], 2'h0} : s;
    @(negedge i_core_clk);
    {i_vid_valid, i_aud_valid, i_rx_valid, i_rx_pixel, i_rx_aud_valid, i_rx_aud_sample} = {2'b00, 1'b1, px, 1'b1, s};
    for (int i = 0; i < cur_dn; i++) qd.push_back({2'(i), ex});
    for (int i = 0; i < cur_an; i++) qs.push_back({18'h0, 4'(i), es});
    @(negedge i_core_clk);
    {i_rx_valid, i_rx_aud_valid} = 2'b00;
    repeat (10) @(negedge i_core_clk);
  endtask

  task automatic done(input string name);
    int n;
    n = 0;
    @(negedge i_core_clk);
    {i_vid_valid, i_aud_valid} = 2'b00;
    while ((qv.size() + qa.size() + qr.size() + qd.size() + qs.size()) != 0 && n < 300) begin
      @(negedge i_core_clk);
      n++;
    end
    check(32'(n < 300), 32'h1);
    $display("test %s done", name);
  endtask

  // Oldest note is matched against each result as it appears
  always @(posedge i_core_clk) begin
    if (o_vid_valid === 1'b1) begin
      check({o_vid_partition, o_vid_pixel}, qv.size() ? qv.pop_front() : 'x);
      check(32'(o_vid_split_half), 32'(cur_parts == 3'h2 && nvout[0]));
      nvout++;
    end
    if (o_disp_valid === 1'b1) check({o_disp_copy_idx, o_disp_pixel}, qd.size() ? qd.pop_front() : 'x);
    if (o_spk_valid === 1'b1) check({18'h0, o_spk_channel, o_spk_sample}, qs.size() ? qs.pop_front() : 'x);
    if (o_aud_valid === 1'b1) check({18'h0, o_aud_channel, o_aud_sample}, qa.size() ? qa.pop_front() : 'x);
    if (o_resp_valid === 1'b1) check({22'h0, o_adapt_result, o_video_active, o_audio_active},
                                     qr.size() ? qr.pop_front() : 'x);
  end

  initial begin
    #(40 * 20000);
    num_errors++;
    print_verdict();
  end

  initial begin
    logic acc;
    int n;
    repeat (16) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_resetn = 1'b1;
    check({20'h0, o_vid_ready, o_resp_valid, o_adapt_result, o_video_active, o_audio_active}, 32'h800);
    for (int i = 0; i < 8; i++) pix(2'(i), 1'b0, 1'b1, acc);
    for (int i = 0; i < 4; i++) aud(4'(i));
    rx();
    done("pass");
    // Refused requests must leave the stream untouched
    req(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 3'h2, RES_INTERLACE, 1'b0);
    req(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h2, RES_FULL, 1'b0);
    req(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0, RES_FULL, 1'b0);
    req(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h5, RES_FULL, 1'b0);
    rdy_mode = 2'h1;
    for (int i = 0; i < 8; i++) pix(2'(i), 1'b0, 1'b1, acc);
    for (int i = 0; i < 4; i++) aud(4'(i));
    done("reject");
    // Back-to-back request is ignored; two partitions and 8-bit colour combined
    req(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h2, RES_FULL, 1'b1);
    for (int i = 0; i < 16; i++) pix(2'(i), 1'b0, 1'b1, acc);
    rx();
    done("partition");
    req(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 3'h4, RES_FULL, 1'b0);
    for (int i = 0; i < 8; i++) aud(4'(i));
    for (int i = 0; i < 8; i++) pix(2'(i), 1'b0, 1'b1, acc);
    rx();
    done("audio");
    // Far side stalls until the buffer refuses, then drains it
    rdy_mode = 2'h2;
    n = 0;
    acc = 1'b1;
    while (acc && n < 20) begin
      pix(2'h3, 1'b0, 1'b1, acc);
      n += int'(acc);
    end
    check(32'(n), 32'h10);
    rdy_mode = 2'h1;
    done("fill");
    req(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h4, RES_INTERLACE, 1'b0);
    for (int f = 0; f < 2; f++) begin
      for (int l = 0; l < 4; l++) pix(2'h0, l == 0, (l % 2) == f, acc);
    end
    done("interlace");
    print_verdict();
  end
endmodule
